/* File: src/report_leaf_pkg.sv */
package report_leaf_pkg;

    // register byte offsets
    localparam logic [11:0] CTRL_OFS    = 12'h000;
    localparam logic [11:0] LEAF_OFS    = 12'h004;
    localparam logic [11:0] TD_OFS      = 12'h008;
    localparam logic [11:0] CD_OFS      = 12'h00C;
    localparam logic [11:0] OUT_OFS     = 12'h010;
    localparam logic [11:0] RBASE_OFS   = 12'h014;
    localparam logic [11:0] RLIMIT_OFS  = 12'h018;
    localparam logic [11:0] CSBASE_OFS  = 12'h01C;
    localparam logic [11:0] MODE_OFS    = 12'h020;
    localparam logic [11:0] STATUS_OFS  = 12'h024;
    localparam logic [11:0] FADDR_OFS   = 12'h028;
    localparam logic [11:0] ISTAT_OFS   = 12'h02C;
    localparam logic [11:0] IMASK_OFS   = 12'h030;
    localparam logic [11:0] PIDX_OFS    = 12'h034;
    localparam logic [11:0] PDATA_OFS   = 12'h038;
    localparam logic [11:0] PMAP_OFS    = 12'h100;

    // leaf index and field codes
    localparam logic [7:0]  LEAF_REPORT = 8'h00;
    localparam logic [3:0]  REGULAR_PAGE_TYPE = 4'h1;
    localparam logic [1:0]  RES_OK      = 2'h0;
    localparam logic [1:0]  RES_GPF     = 2'h1;
    localparam logic [1:0]  RES_PF      = 2'h2;
    localparam int          CANON_BIT   = 23;

    // report layout in 32-bit words
    localparam int PLAT_WORDS  = 20;
    localparam int TD_WORDS    = 32;
    localparam int W_CSTRUCT   = 4;
    localparam int W_RESERVED  = 72;
    localparam int W_CALLER    = 80;
    localparam int W_KEYTAG    = 96;
    localparam int W_MAC       = 104;
    localparam int W_END       = 108;
    localparam int PLAT_KEYTAG = 4;

    typedef struct packed {
        logic [7:0] enclave_id;
        logic [3:0] page_type;
        logic       writable;
        logic       readable;
        logic       modified;
        logic       pending;
        logic       blocked;
        logic       valid;
    } page_flags_s;

    typedef struct packed {
        logic        req;
        logic        we;
        logic [31:0] addr;
        logic [31:0] wdata;
    } mem_cmd_s;

    typedef enum logic [2:0] {
        IDLE, CHECK, KEY_RD, BUILD_RD, BUILD_WR, MAC_WR
    } leaf_state_e;

endpackage

/* File: src/report_leaf.sv */
// Chosen here: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps

// Functional notes
// - descriptor 512-byte aligned, in range, else gp fault
// - caller data 128-byte aligned, in range, else gp fault
// - output buffer 512-byte aligned, in range, else gp fault
// - operand outside page cache: page fault at its address
// - map entry invalid or blocked: page fault
// - bad type, enclave, pending, modified or address: page fault
// - descriptor, caller pages readable; output page writable
// - operands in order; range, mapping, validity, attributes
// - report from control structure, security version, caller data
// - reserved measurement zero, key tag from platform
// - key inputs from descriptor and platform, rest zero
// - 128-bit key, mac over report bits 3071:0
// - report bits 3455:0 written after checks pass
// - operand outside current enclave: gp fault
// - 64-bit mode, non-canonical caller address: gp fault
// - leaf index 00h selects report creation
module report_leaf
    import report_leaf_pkg::*;
#(
    parameter int NPAGES = 8
)(
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [11:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             irq,
    output logic             mem_req,
    output logic             mem_we,
    output logic      [31:0] mem_addr,
    output logic      [31:0] mem_wdata,
    input  wire logic        mem_ack,
    input  wire logic [31:0] mem_rdata
);
    localparam int IW = $clog2(NPAGES);

    leaf_state_e  state_reg;
    logic [1:0]   op_reg;
    logic [1:0]   stage_reg;
    logic [6:0]   word_reg;
    logic [31:0]  cur_reg;
    logic         start_reg;
    logic [7:0]   leaf_reg;
    logic [31:0]  td_reg;
    logic [31:0]  cd_reg;
    logic [31:0]  out_reg;
    logic [31:0]  rbase_reg;
    logic [31:0]  rlimit_reg;
    logic [31:0]  csbase_reg;
    logic         mode64_reg;
    logic [7:0]   active_id_reg;
    logic [1:0]   result_reg;
    logic [1:0]   fault_op_reg;
    logic [31:0]  fault_addr_reg;
    logic [1:0]   istat_reg;
    logic [1:0]   imask_reg;
    logic         done_pulse_reg;
    logic         fault_pulse_reg;
    logic [4:0]   pidx_reg;
    logic [31:0]  plat_reg [PLAT_WORDS];
    logic [19:0]  pm_page_reg [NPAGES];
    logic         pm_present_reg [NPAGES];
    page_flags_s  pm_flags_reg [NPAGES];
    logic [19:0]  pm_rec_reg [NPAGES];
    logic [31:0]  key_reg [4];
    logic [31:0]  mac_reg [4];
    mem_cmd_s     mem_reg;

    logic         wb_hit;
    logic         wb_wr;
    logic [31:0]  rd_next;
    logic [31:0]  opaddr;
    logic         misaligned;
    logic         noncanon;
    logic         out_range;
    logic [NPAGES-1:0] hit_vec;
    logic [IW-1:0] hit_idx;
    page_flags_s  hf;
    logic         bad_attr;
    logic         fail;
    logic         mem_done;
    logic         src_mem;
    logic [31:0]  src_addr;
    logic [31:0]  src_int;
    logic [31:0]  key_seed [4];
    logic         pm_hit;
    logic [IW-1:0] pm_sel;

    assign wb_hit   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wb_wr    = wb_hit & wb_we_i & (&wb_sel_i);
    assign mem_done = mem_reg.req & mem_ack;
    assign mem_req   = mem_reg.req;
    assign mem_we    = mem_reg.we;
    assign mem_addr  = mem_reg.addr;
    assign mem_wdata = mem_reg.wdata;
    assign pm_sel    = wb_adr_i[IW+3:4];
    assign pm_hit    = wb_adr_i[11:8] == PMAP_OFS[11:8]
                     && {28'h0, wb_adr_i[7:4]} < NPAGES;

    // operand under check
    always_comb
    begin
        unique case (op_reg)
            2'd0:    opaddr = td_reg;
            2'd1:    opaddr = cd_reg;
            default: opaddr = out_reg;
        endcase
        misaligned = (op_reg == 2'd1) ? (opaddr[6:0] != 7'h00)
                                      : (opaddr[8:0] != 9'h000);
        out_range = (opaddr < rbase_reg) | (opaddr > rlimit_reg);
        noncanon = mode64_reg & (op_reg == 2'd1)
                 & (|opaddr[31:CANON_BIT]) & ~(&opaddr[31:CANON_BIT]);
    end

    // page map lookup
    for (genvar i = 0; i < NPAGES; i++)
    begin : g_hit
        assign hit_vec[i] = pm_present_reg[i]
                          & (pm_page_reg[i] == opaddr[31:12]);
    end

    always_comb
    begin
        hit_idx = '0;
        for (int i = NPAGES - 1; i >= 0; i--)
        begin
            if (hit_vec[i])
            begin
                hit_idx = IW'(i);
            end
        end
        hf = pm_flags_reg[hit_idx];
        bad_attr = (hf.page_type != REGULAR_PAGE_TYPE)
                 | (hf.enclave_id != active_id_reg)
                 | hf.pending | hf.modified
                 | (pm_rec_reg[hit_idx] != opaddr[31:12]);
        if (op_reg == 2'd2)
        begin
            bad_attr = bad_attr | ~hf.writable;
        end
        else
        begin
            bad_attr = bad_attr | ~hf.readable;
        end
        unique case (stage_reg)
            2'd0:    fail = misaligned | out_range | noncanon;
            2'd1:    fail = ~(|hit_vec);
            2'd2:    fail = ~hf.valid | hf.blocked;
            default: fail = bad_attr;
        endcase
    end

    // report word source
    always_comb
    begin
        src_mem  = 1'b0;
        src_addr = '0;
        src_int  = '0;
        if (word_reg < 7'(W_CSTRUCT))
        begin
            src_int = plat_reg[word_reg[1:0]];
        end
        else if (word_reg < 7'(W_RESERVED))
        begin
            src_mem  = 1'b1;
            src_addr = csbase_reg
                     + {23'h0, word_reg - 7'(W_CSTRUCT), 2'b00};
        end
        else if (word_reg < 7'(W_CALLER))
        begin
            src_int = '0;
        end
        else if (word_reg < 7'(W_KEYTAG))
        begin
            src_mem  = 1'b1;
            src_addr = cd_reg
                     + {23'h0, word_reg - 7'(W_CALLER), 2'b00};
        end
        else
        begin
            src_int = plat_reg[5'(PLAT_KEYTAG)
                             + 5'(word_reg - 7'(W_KEYTAG))];
        end
    end

    // key seed from platform bank
    always_comb
    begin
        key_seed = '{default: '0};
        for (int j = 0; j < PLAT_WORDS; j++)
        begin
            key_seed[j % 4] = key_seed[j % 4] ^ plat_reg[j];
        end
    end

    // sequencer
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            state_reg       <= IDLE;
            op_reg          <= 2'd0;
            stage_reg       <= 2'd0;
            word_reg        <= '0;
            cur_reg         <= '0;
            result_reg      <= RES_OK;
            fault_op_reg    <= 2'd0;
            fault_addr_reg  <= '0;
            done_pulse_reg  <= 1'b0;
            fault_pulse_reg <= 1'b0;
        end
        else
        begin
            done_pulse_reg  <= 1'b0;
            fault_pulse_reg <= 1'b0;
            unique case (state_reg)
                IDLE:
                begin
                    if (start_reg && leaf_reg != LEAF_REPORT)
                    begin
                        result_reg      <= RES_GPF;
                        fault_addr_reg  <= '0;
                        fault_op_reg    <= 2'd0;
                        fault_pulse_reg <= 1'b1;
                    end
                    else if (start_reg)
                    begin
                        state_reg  <= CHECK;
                        op_reg     <= 2'd0;
                        stage_reg  <= 2'd0;
                        result_reg <= RES_OK;
                    end
                end
                CHECK:
                begin
                    if (fail)
                    begin
                        state_reg       <= IDLE;
                        result_reg      <= (stage_reg == 2'd0) ? RES_GPF
                                                               : RES_PF;
                        fault_addr_reg  <= (stage_reg == 2'd0) ? '0
                                                               : opaddr;
                        fault_op_reg    <= op_reg;
                        fault_pulse_reg <= 1'b1;
                    end
                    else
                    begin
                        stage_reg <= stage_reg + 2'd1;
                        if (stage_reg == 2'd3)
                        begin
                            op_reg <= op_reg + 2'd1;
                            if (op_reg == 2'd2)
                            begin
                                state_reg <= KEY_RD;
                                word_reg  <= '0;
                            end
                        end
                    end
                end
                KEY_RD:
                begin
                    if (mem_done)
                    begin
                        word_reg <= word_reg + 7'd1;
                        if (word_reg == 7'(TD_WORDS - 1))
                        begin
                            state_reg <= BUILD_RD;
                            word_reg  <= '0;
                        end
                    end
                end
                BUILD_RD:
                begin
                    if (!src_mem)
                    begin
                        cur_reg   <= src_int;
                        state_reg <= BUILD_WR;
                    end
                    else if (mem_done)
                    begin
                        cur_reg   <= mem_rdata;
                        state_reg <= BUILD_WR;
                    end
                end
                BUILD_WR:
                begin
                    if (mem_done)
                    begin
                        word_reg  <= word_reg + 7'd1;
                        state_reg <= (word_reg == 7'(W_MAC - 1)) ? MAC_WR
                                                                 : BUILD_RD;
                    end
                end
                MAC_WR:
                begin
                    if (mem_done)
                    begin
                        word_reg <= word_reg + 7'd1;
                        if (word_reg == 7'(W_END - 1))
                        begin
                            state_reg      <= IDLE;
                            done_pulse_reg <= 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    // memory master
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            mem_reg <= '0;
        end
        else if (mem_reg.req)
        begin
            if (mem_ack)
            begin
                mem_reg.req <= 1'b0;
            end
        end
        else
        begin
            unique case (state_reg)
                KEY_RD:
                begin
                    mem_reg <= {1'b1, 1'b0,
                        td_reg + {23'h0, word_reg, 2'b00}, 32'h0};
                end
                BUILD_RD:
                begin
                    mem_reg <= {src_mem, 1'b0, src_addr, 32'h0};
                end
                BUILD_WR:
                begin
                    mem_reg <= {1'b1, 1'b1,
                        out_reg + {23'h0, word_reg, 2'b00}, cur_reg};
                end
                MAC_WR:
                begin
                    mem_reg <= {1'b1, 1'b1,
                        out_reg + {23'h0, word_reg, 2'b00},
                        mac_reg[word_reg[1:0]]};
                end
                default:
                begin
                    mem_reg <= '0;
                end
            endcase
        end
    end

    // key derivation and mac stand-in
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            for (int k = 0; k < 4; k++)
            begin
                key_reg[k] <= '0;
                mac_reg[k] <= '0;
            end
        end
        else if (state_reg == CHECK)
        begin
            for (int k = 0; k < 4; k++)
            begin
                key_reg[k] <= key_seed[k];
                mac_reg[k] <= '0;
            end
        end
        else if (state_reg == KEY_RD && mem_done)
        begin
            key_reg[word_reg[1:0]] <= key_reg[word_reg[1:0]]
                                    ^ mem_rdata;
        end
        else if (state_reg == BUILD_WR && mem_done
                 && word_reg < 7'(W_KEYTAG))
        begin
            mac_reg[word_reg[1:0]] <= {mac_reg[word_reg[1:0]][26:0],
                                       mac_reg[word_reg[1:0]][31:27]}
                                    ^ cur_reg
                                    ^ key_reg[word_reg[1:0]];
        end
    end

    // software registers
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            start_reg     <= 1'b0;
            leaf_reg      <= LEAF_REPORT;
            td_reg        <= '0;
            cd_reg        <= '0;
            out_reg       <= '0;
            rbase_reg     <= '0;
            rlimit_reg    <= '0;
            csbase_reg    <= '0;
            mode64_reg    <= 1'b0;
            active_id_reg <= '0;
            imask_reg     <= '0;
            pidx_reg      <= '0;
        end
        else
        begin
            start_reg <= wb_wr && wb_adr_i == CTRL_OFS && wb_dat_i[0]
                      && state_reg == IDLE;
            if (wb_wr)
            begin
                unique case (wb_adr_i)
                    LEAF_OFS:   leaf_reg   <= wb_dat_i[7:0];
                    TD_OFS:     td_reg     <= wb_dat_i;
                    CD_OFS:     cd_reg     <= wb_dat_i;
                    OUT_OFS:    out_reg    <= wb_dat_i;
                    RBASE_OFS:  rbase_reg  <= wb_dat_i;
                    RLIMIT_OFS: rlimit_reg <= wb_dat_i;
                    CSBASE_OFS: csbase_reg <= wb_dat_i;
                    MODE_OFS:
                    begin
                        mode64_reg    <= wb_dat_i[0];
                        active_id_reg <= wb_dat_i[15:8];
                    end
                    IMASK_OFS:  imask_reg  <= wb_dat_i[1:0];
                    PIDX_OFS:   pidx_reg   <= wb_dat_i[4:0];
                    default:    ;
                endcase
            end
        end
    end

    // platform bank and page map
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            for (int j = 0; j < PLAT_WORDS; j++)
            begin
                plat_reg[j] <= '0;
            end
            for (int i = 0; i < NPAGES; i++)
            begin
                pm_page_reg[i]    <= '0;
                pm_present_reg[i] <= 1'b0;
                pm_flags_reg[i]   <= '0;
                pm_rec_reg[i]     <= '0;
            end
        end
        else if (wb_wr)
        begin
            if (wb_adr_i == PDATA_OFS && pidx_reg < 5'(PLAT_WORDS))
            begin
                plat_reg[pidx_reg] <= wb_dat_i;
            end
            if (pm_hit)
            begin
                unique case (wb_adr_i[3:2])
                    2'd0:
                    begin
                        pm_page_reg[pm_sel]    <= wb_dat_i[31:12];
                        pm_present_reg[pm_sel] <= wb_dat_i[0];
                    end
                    2'd1: pm_flags_reg[pm_sel] <= wb_dat_i[17:0];
                    2'd2: pm_rec_reg[pm_sel] <= wb_dat_i[31:12];
                    default: ;
                endcase
            end
        end
    end

    // w1c status, set wins
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            istat_reg <= '0;
            irq       <= 1'b0;
        end
        else
        begin
            istat_reg <= (istat_reg
                & ~((wb_wr && wb_adr_i == ISTAT_OFS) ? wb_dat_i[1:0] : 2'b00))
                | {fault_pulse_reg, done_pulse_reg};
            irq <= |(istat_reg & imask_reg);
        end
    end

    // read mux
    always_comb
    begin
        rd_next = '0;
        unique case (wb_adr_i)
            LEAF_OFS:   rd_next = {24'h0, leaf_reg};
            TD_OFS:     rd_next = td_reg;
            CD_OFS:     rd_next = cd_reg;
            OUT_OFS:    rd_next = out_reg;
            RBASE_OFS:  rd_next = rbase_reg;
            RLIMIT_OFS: rd_next = rlimit_reg;
            CSBASE_OFS: rd_next = csbase_reg;
            MODE_OFS:   rd_next = {16'h0, active_id_reg, 7'h0, mode64_reg};
            STATUS_OFS: rd_next = {27'h0, fault_op_reg, result_reg,
                                   state_reg != IDLE};
            FADDR_OFS:  rd_next = fault_addr_reg;
            ISTAT_OFS:  rd_next = {30'h0, istat_reg};
            IMASK_OFS:  rd_next = {30'h0, imask_reg};
            PIDX_OFS:   rd_next = {27'h0, pidx_reg};
            PDATA_OFS:
            begin
                if (pidx_reg < 5'(PLAT_WORDS))
                begin
                    rd_next = plat_reg[pidx_reg];
                end
            end
            default:
            begin
                if (pm_hit)
                begin
                    unique case (wb_adr_i[3:2])
                        2'd0: rd_next = {pm_page_reg[pm_sel], 11'h0,
                                         pm_present_reg[pm_sel]};
                        2'd1: rd_next = {14'h0, pm_flags_reg[pm_sel]};
                        2'd2: rd_next = {pm_rec_reg[pm_sel], 12'h0};
                        default: rd_next = '0;
                    endcase
                end
            end
        endcase
    end

    // wishbone answer
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end
        else
        begin
            wb_ack_o <= wb_hit;
            wb_dat_o <= wb_hit ? rd_next : '0;
        end
    end

endmodule // report_leaf

/* File: verification/report_leaf_sva.sv */
`timescale 1ns/1ps
module report_leaf_sva (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    input wire logic        mem_req,
    input wire logic        mem_we,
    input wire logic [31:0] mem_addr,
    input wire logic        mem_ack
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=>
        wb_ack_o) else $error("ack late");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held");
    a_ack_cause: assert property ($rose(wb_ack_o) |->
        $past(wb_cyc_i && wb_stb_i)) else $error("ack unasked");
    a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("data not zero");
    a_req_hold: assert property (mem_req && !mem_ack |=> mem_req &&
        $stable(mem_addr) && $stable(mem_we)) else $error("req moved");
    a_req_drop: assert property (mem_req && mem_ack |=> !mem_req)
        else $error("req not dropped");
    a_wr_align: assert property (mem_req && mem_we |->
        mem_addr[1:0] == 2'h0) else $error("write unaligned");
    a_rd_align: assert property (mem_req && !mem_we |->
        mem_addr[1:0] == 2'h0) else $error("read unaligned");
endmodule // report_leaf_sva

bind report_leaf report_leaf_sva u_report_leaf_sva (.*);

/* File: verification/report_mem.sv */
`timescale 1ns/1ps
module report_mem (
    input  wire logic        clk,
    input  wire logic        req,
    input  wire logic        we,
    input  wire logic [31:0] addr,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  lat,
    output logic             ack = 1'b0,
    output logic      [31:0] rdata = 32'h0
);
    logic [31:0] m [logic [31:0]];
    int          nwr;
    int          w;
    always @(posedge clk)
    begin
        ack <= 1'b0;
        rdata <= ~rdata;
        if (req && !ack && w < lat)
            w <= w + 1;
        else if (req && !ack)
        begin
            ack <= 1'b1;
            w <= 0;
            rdata <= addr ^ 32'h5A5A_5A5A;
            if (we)
            begin
                m[addr] = wdata;
                nwr++;
            end
        end
    end
endmodule // report_mem

/* File: verification/report_leaf_bench.sv */
`timescale 1ns/1ps
module report_leaf_bench;
    import report_leaf_pkg::*;
    logic        clk, irq, wb_ack_o, mem_req, mem_we, mem_ack, ie = 1'b1;
    logic        resetn = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [3:0]  wb_sel_i = 4'hF, lat = 4'h0;
    logic [11:0] wb_adr_i = 12'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, mem_addr, mem_wdata, mem_rdata, q;
    int          err_total, checks_done, ncyc;
    localparam logic [31:0] FL = 32'h1471;
    localparam logic [31:0] XR = 32'h5A5A_5A5A;
    report_leaf u_report_leaf (.clk(clk), .resetn(resetn), .irq(irq),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mem_req(mem_req),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata));
    report_mem u_report_mem (.clk(clk), .req(mem_req), .we(mem_we),
        .addr(mem_addr), .wdata(mem_wdata), .lat(lat), .ack(mem_ack),
        .rdata(mem_rdata));
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic test_done();
        $display("errors %0d checks %0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge clk)
    begin
        ncyc++;
        if (ncyc == 20000)
        begin
            err_total++;
            test_done();
        end
    end
    task automatic chk(input logic [31:0] got, exp);
        checks_done++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do
            @(posedge clk);
        while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic run(input logic [31:0] st, input logic [31:0] fa);
        int n0;
        n0 = u_report_mem.nwr;
        wb(1, ISTAT_OFS, 32'h3);
        wb(1, CTRL_OFS, 32'h1);
        q = 32'h1;
        while (q[0] === 1'b1)
            wb(0, STATUS_OFS, 32'h0);
        chk(q & 32'h1E, st);
        wb(0, FADDR_OFS, 32'h0);
        chk(q, fa);
        wb(0, ISTAT_OFS, 32'h0);
        chk(q, (st != 0) ? 32'h2 : 32'h1);
        chk({31'h0, irq}, {31'h0, ie});
        if (st != 0)
            chk(32'(u_report_mem.nwr - n0), 32'h0);
        wb(1, ISTAT_OFS, 32'h3);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
    endtask
    task automatic ft(input logic [11:0] a, input logic [31:0] bad, good,
                      st, fa);
        wb(1, a, bad);
        run(st, fa);
        wb(1, a, good);
    endtask
    function automatic logic [31:0] rw(input int w);
        if (w < 4) return 32'hC0DE_0000 + 32'(w);
        if (w < 72) return (32'h14000 + 32'(4 * (w - 4))) ^ XR;
        if (w < 80) return 32'h0;
        if (w < 96) return (32'h11000 + 32'(4 * (w - 80))) ^ XR;
        return 32'hC0DE_0000 + 32'(w - 92);
    endfunction
    task automatic ok_run(input logic [3:0] l);
        logic [31:0] k [4], mc [4];
        k = '{default: 32'h0};
        mc = '{default: 32'h0};
        lat <= l;
        u_report_mem.m.delete();
        run(32'h0, 32'h0);
        for (int j = 0; j < 20; j++) k[j%4] ^= 32'hC0DE_0000 + 32'(j);
        for (int j = 0; j < 32; j++) k[j%4] ^= (32'h10000 + 32'(4*j)) ^ XR;
        for (int j = 0; j < 96; j++)
            mc[j%4] = {mc[j%4][26:0], mc[j%4][31:27]} ^ rw(j) ^ k[j%4];
        for (int j = 0; j < 108; j++)
            chk(u_report_mem.m[32'h12000 + 32'(4*j)],
                (j < 104) ? rw(j) : mc[j-104]);
    endtask
    initial
    begin
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        wb(0, LEAF_OFS, 32'h0);
        chk(q, 32'h0);
        wb(0, 12'h0FC, 32'h0);
        chk(q, 32'h0);
        wb(1, RBASE_OFS, 32'h10000);
        wb(1, RLIMIT_OFS, 32'h1FFFF);
        wb(1, CSBASE_OFS, 32'h14000);
        wb(1, MODE_OFS, 32'h500);
        wb(1, IMASK_OFS, 32'h3);
        wb(1, TD_OFS, 32'h10000);
        wb(1, CD_OFS, 32'h11000);
        wb(1, OUT_OFS, 32'h12000);
        for (int j = 0; j < 20; j++)
        begin
            wb(1, PIDX_OFS, 32'(j));
            wb(1, PDATA_OFS, 32'hC0DE_0000 + 32'(j));
        end
        for (int i = 0; i < 3; i++)
        begin
            wb(1, 12'(PMAP_OFS + 16*i), 32'h10001 + 32'(i * 4096));
            wb(1, 12'(PMAP_OFS + 16*i + 4), FL);
            wb(1, 12'(PMAP_OFS + 16*i + 8), 32'h10000 + 32'(i * 4096));
        end
        ok_run(4'h0);
        ok_run(4'h3);
        ft(TD_OFS, 32'h10100, 32'h10000, 32'h02, 0);
        ft(CD_OFS, 32'h11040, 32'h11000, 32'h0A, 0);
        ft(OUT_OFS, 32'h12100, 32'h12000, 32'h12, 0);
        ft(OUT_OFS, 32'h20000, 32'h12000, 32'h12, 0);
        ft(12'h110, 32'h11000, 32'h11001, 32'h0C, 32'h11000);
        ft(12'h114, 32'h1470, FL, 32'h0C, 32'h11000);
        ft(12'h114, 32'h1473, FL, 32'h0C, 32'h11000);
        ft(12'h104, 32'h14B1, FL, 32'h04, 32'h10000);
        ft(12'h104, 32'h1871, FL, 32'h04, 32'h10000);
        ft(12'h104, 32'h1475, FL, 32'h04, 32'h10000);
        ft(12'h124, 32'h1479, FL, 32'h14, 32'h12000);
        ft(12'h108, 32'h13000, 32'h10000, 32'h04, 32'h10000);
        ft(12'h114, 32'h1461, FL, 32'h0C, 32'h11000);
        ft(12'h124, 32'h1451, FL, 32'h14, 32'h12000);
        wb(1, 12'h124, 32'h1470);
        ft(CD_OFS, 32'h11040, 32'h11000, 32'h0A, 0);
        ft(12'h114, 32'h1470, FL, 32'h0C, 32'h11000);
        wb(1, 12'h124, FL);
        wb(1, RLIMIT_OFS, 32'hFFFF_FFFF);
        wb(1, MODE_OFS, 32'h501);
        ft(CD_OFS, 32'h0081_1000, 32'h11000, 32'h0A, 0);
        ie = 1'b0;
        wb(1, IMASK_OFS, 32'h0);
        ft(LEAF_OFS, 32'h1, 32'h0, 32'h02, 0);
        test_done();
    end
endmodule // report_leaf_bench
